//--- hw/pvs_pkg.sv
// Purpose: shared constants of the process value supervisor
// Assumes: 32-bit plain register port, word offsets are byte addresses
// Notes: values are 16-bit signed scaled process units
package pvs_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int NALM = 6;
    localparam int NEVT = 8;
    // timing
    localparam longint CLK_NS = 10;
    localparam longint SEC_NS = 1000000000;
    localparam longint SEC_CYCLES = SEC_NS / CLK_NS;
    localparam int DAY_SEC = 86400;
    localparam int ONDLY_MAX_S = 60;
    localparam int RINT_MIN_S = 1;
    localparam int RINT_MAX_S = 16;
    localparam int AVG_MAX = 128;
    localparam int OVR_HI_PCT = 115;
    localparam int OVR_LO_PCT = -15;
    localparam int PCT = 100;
    // control bits
    localparam int CTL_HOLD = 0;
    localparam int CTL_DIRHI = 1;
    localparam int CTL_CAL = 2;
    // offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_AVGN = 8'h04;
    localparam logic [7:0] A_RLO = 8'h08;
    localparam logic [7:0] A_RHI = 8'h0c;
    localparam logic [7:0] A_THR0 = 8'h10;
    localparam logic [7:0] A_HYPV = 8'h28;
    localparam logic [7:0] A_HYRT = 8'h2c;
    localparam logic [7:0] A_ONDLY = 8'h30;
    localparam logic [7:0] A_RINT = 8'h34;
    localparam logic [7:0] A_CPER = 8'h38;
    localparam logic [7:0] A_NOTE = 8'h3c;
    localparam logic [7:0] A_PV = 8'h40;
    localparam logic [7:0] A_RATE = 8'h44;
    localparam logic [7:0] A_FLAGS = 8'h48;
    localparam logic [7:0] A_PEAK = 8'h4c;
    localparam logic [7:0] A_BOT = 8'h50;
    localparam logic [7:0] A_TOP = 8'h54;
    localparam logic [7:0] A_VAL = 8'h58;
    localparam logic [7:0] A_DAY = 8'h5c;
    localparam logic [7:0] A_CDAY = 8'h60;
    localparam logic [7:0] A_IST = 8'h64;
    localparam logic [7:0] A_ICLR = 8'h68;
    localparam logic [7:0] A_IEN = 8'h6c;
    // reset values
    localparam logic [7:0] R_AVGN = 8'h04;
    localparam logic [15:0] R_RHI = 16'h2710;
    localparam logic [4:0] R_RINT = 5'h01;
endpackage

//--- hw/pvs_supervisor.sv
// Purpose: post-processing of one converted temperature input
// Assumes: one sample per sample_vld_i pulse, open_raw_i from front end
// Notes: alarm order upper_critical, upper, lower, bottom_critical,
//        rate upper, rate lower
`timescale 1ns/100ps
`default_nettype none
module pvs_supervisor #(
    parameter longint SEC_CYC = pvs_pkg::SEC_CYCLES,
    parameter int DAY_S = pvs_pkg::DAY_SEC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // converter side
    input wire logic sample_vld_i,
    input wire logic [15:0] sample_i,
    input wire logic open_raw_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // status
    output logic open_flag_o,
    output logic [5:0] alarm_o,
    output logic warn_o,
    output logic irq_o
);
    localparam int DW = pvs_pkg::DW;
    typedef logic signed [DW:0] pvs_wide_t;

    function automatic pvs_wide_t ext(input logic [DW-1:0] v);
        ext = {v[DW-1], v};
    endfunction

    logic [2:0] ctrl_q;
    logic [7:0] avgn_q;
    logic [15:0] rlo_q, rhi_q, hypv_q, hyrt_q, cper_q, note_q;
    logic [15:0] thr_q [pvs_pkg::NALM];
    logic [5:0] ondly_q;
    logic [4:0] rint_q;
    logic [7:0] ist_q, ien_q;
    logic [15:0] pv_q, rate_q, peak_q, bot_q, top_q, val_q;
    logic [15:0] day_q, cday_q;
    logic cal_q, sec_tick, hold_d1_q;
    logic [7:0] flags;

    // register writes; the calibration bit is a self-clearing command
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= 3'h0;
            avgn_q <= pvs_pkg::R_AVGN;
            rlo_q <= 16'h0000;
            rhi_q <= pvs_pkg::R_RHI;
            hypv_q <= 16'h0000;
            hyrt_q <= 16'h0000;
            ondly_q <= 6'h00;
            rint_q <= pvs_pkg::R_RINT;
            cper_q <= 16'h0000;
            note_q <= 16'h0000;
            ien_q <= 8'h00;
            for (int i = 0; i < pvs_pkg::NALM; i++) thr_q[i] <= 16'h0000;
        end else begin
            ctrl_q[pvs_pkg::CTL_CAL] <= 1'b0;
            if (wr_i) begin
                case (addr_i)
                    pvs_pkg::A_CTRL: ctrl_q <= wdata_i[2:0];
                    pvs_pkg::A_AVGN: avgn_q <= (wdata_i[7:0] == 8'h00) ?
                        8'h01 : (wdata_i[7:0] > 8'h80 ? 8'h80 : wdata_i[7:0]);
                    pvs_pkg::A_RLO: rlo_q <= wdata_i[15:0];
                    pvs_pkg::A_RHI: rhi_q <= wdata_i[15:0];
                    pvs_pkg::A_HYPV: hypv_q <= wdata_i[15:0];
                    pvs_pkg::A_HYRT: hyrt_q <= wdata_i[15:0];
                    pvs_pkg::A_ONDLY: ondly_q <= (wdata_i[5:0] > 6'h3c) ?
                        6'h3c : wdata_i[5:0];
                    pvs_pkg::A_RINT: rint_q <= (wdata_i[4:0] == 5'h00) ? 5'h01
                        : (wdata_i[4:0] > 5'h10 ? 5'h10 : wdata_i[4:0]);
                    pvs_pkg::A_CPER: cper_q <= wdata_i[15:0];
                    pvs_pkg::A_NOTE: note_q <= wdata_i[15:0];
                    pvs_pkg::A_IEN: ien_q <= wdata_i[7:0];
                    default: begin
                        for (int i = 0; i < pvs_pkg::NALM; i++) begin
                            if (addr_i == pvs_pkg::A_THR0 + 8'(4 * i)) begin
                                thr_q[i] <= wdata_i[15:0];
                            end
                        end
                    end
                endcase
            end
        end
    end
    assign cal_q = ctrl_q[pvs_pkg::CTL_CAL];

    // one-second time base and day counter
    logic [31:0] cyc_q;
    logic [31:0] secs_q;
    assign sec_tick = (cyc_q == 32'(SEC_CYC - 1));
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_q <= 32'h0;
            secs_q <= 32'h0;
            day_q <= 16'h0000;
        end else begin
            cyc_q <= sec_tick ? 32'h0 : cyc_q + 32'h1;
            if (sec_tick) begin
                secs_q <= (secs_q == 32'(DAY_S - 1)) ? 32'h0 : secs_q + 32'h1;
                if (secs_q == 32'(DAY_S - 1)) day_q <= day_q + 16'h1;
            end
        end
    end

    // open sensor: front end reports within its own detection time
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) open_flag_o <= 1'b0;
        else open_flag_o <= open_raw_i;
    end

    // moving average; window restarts when its length is changed
    logic [15:0] buf_q [pvs_pkg::AVG_MAX];
    logic [6:0] wp_q;
    logic [7:0] fill_q, avgn_d1_q;
    logic signed [23:0] sum_q;
    logic [15:0] old_s;
    assign old_s = buf_q[7'(wp_q - avgn_q[6:0])];
    always_ff @(posedge clk_i) begin
        if (sample_vld_i) buf_q[wp_q] <= sample_i;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q <= 7'h00;
            fill_q <= 8'h00;
            sum_q <= 24'sh0;
            avgn_d1_q <= pvs_pkg::R_AVGN;
        end else begin
            avgn_d1_q <= avgn_q;
            if (avgn_d1_q != avgn_q) begin
                fill_q <= 8'h00;
                sum_q <= 24'sh0;
            end else if (sample_vld_i) begin
                wp_q <= wp_q + 7'h1;
                if (fill_q < avgn_q) begin
                    fill_q <= fill_q + 8'h1;
                    sum_q <= sum_q + 24'(signed'(sample_i));
                end else begin
                    sum_q <= sum_q + 24'(signed'(sample_i))
                        - 24'(signed'(old_s));
                end
            end
        end
    end

    // process value: average, or overrange value while broken
    logic signed [31:0] span, ovr, avg;
    logic vld_d1_q;
    assign span = 32'(signed'(rhi_q)) - 32'(signed'(rlo_q));
    assign ovr = 32'(signed'(rlo_q)) + (ctrl_q[pvs_pkg::CTL_DIRHI] ?
        span * pvs_pkg::OVR_HI_PCT : span * pvs_pkg::OVR_LO_PCT) / pvs_pkg::PCT;
    assign avg = (fill_q == 8'h00) ? 32'sh0 :
        32'(sum_q) / signed'({24'h0, fill_q});
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pv_q <= 16'h0000;
            vld_d1_q <= 1'b0;
        end else begin
            vld_d1_q <= sample_vld_i;
            if (open_flag_o) pv_q <= ovr[15:0];
            else if (vld_d1_q) pv_q <= avg[15:0];
        end
    end

    // rate of change over the comparison interval
    logic [4:0] rcnt_q;
    logic [15:0] pv_old_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rcnt_q <= 5'h00;
            pv_old_q <= 16'h0000;
            rate_q <= 16'h0000;
        end else if (sec_tick) begin
            if (rcnt_q + 5'h1 >= rint_q) begin
                rcnt_q <= 5'h00;
                pv_old_q <= pv_q;
                rate_q <= pv_q - pv_old_q;
            end else begin
                rcnt_q <= rcnt_q + 5'h1;
            end
        end
    end

    // alarms: hysteresis latch then shared on-delay
    logic [5:0] raw_q;
    logic [5:0] dcnt_q [pvs_pkg::NALM];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_q <= 6'h00;
            alarm_o <= 6'h00;
            for (int i = 0; i < pvs_pkg::NALM; i++) dcnt_q[i] <= 6'h00;
        end else begin
            for (int i = 0; i < pvs_pkg::NALM; i++) begin
                automatic pvs_wide_t v = ext(i < 4 ? pv_q : rate_q);
                automatic pvs_wide_t t = ext(thr_q[i]);
                automatic pvs_wide_t h = ext(i < 4 ? hypv_q : hyrt_q);
                automatic logic hi = (i == 0 || i == 1 || i == 4);
                if (hi ? (v >= t) : (v <= t)) raw_q[i] <= 1'b1;
                else if (hi ? (v < t - h) : (v > t + h))
                    raw_q[i] <= 1'b0;
                if (!raw_q[i]) begin
                    dcnt_q[i] <= 6'h00;
                    alarm_o[i] <= 1'b0;
                end else if (dcnt_q[i] >= ondly_q) begin
                    alarm_o[i] <= 1'b1;
                end else if (sec_tick) begin
                    dcnt_q[i] <= dcnt_q[i] + 6'h1;
                end
            end
        end
    end

    // adjustment period
    logic [16:0] due;
    assign due = {1'b0, cper_q} - {1'b0, note_q};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cday_q <= 16'h0000;
            warn_o <= 1'b0;
        end else begin
            if (cal_q) cday_q <= day_q;
            // negative due means the notice covers the whole period
            warn_o <= (cper_q != 16'h0000) && !cal_q &&
                (due[16] || {1'b0, day_q - cday_q} >= due);
        end
    end

    // peak/bottom and top/valley inside the host hold window
    logic hold;
    logic [1:0] dir_q;
    logic [15:0] prev_q;
    assign hold = ctrl_q[pvs_pkg::CTL_HOLD];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_d1_q <= 1'b0;
            peak_q <= 16'h0000;
            bot_q <= 16'h0000;
            top_q <= 16'h0000;
            val_q <= 16'h0000;
            prev_q <= 16'h0000;
            dir_q <= 2'h0;
        end else begin
            hold_d1_q <= hold;
            if (hold && !hold_d1_q) begin
                peak_q <= pv_q;
                bot_q <= pv_q;
                top_q <= pv_q;
                val_q <= pv_q;
                prev_q <= pv_q;
                dir_q <= 2'h0;
            end else if (hold) begin
                if ($signed(pv_q) > $signed(peak_q)) peak_q <= pv_q;
                if ($signed(pv_q) < $signed(bot_q)) bot_q <= pv_q;
                prev_q <= pv_q;
                // turning points: rise then fall is a top, and the reverse
                if ($signed(pv_q) > $signed(prev_q)) begin
                    if (dir_q == 2'h2) val_q <= prev_q;
                    dir_q <= 2'h1;
                end else if ($signed(pv_q) < $signed(prev_q)) begin
                    if (dir_q == 2'h1) top_q <= prev_q;
                    dir_q <= 2'h2;
                end
            end
        end
    end

    // interrupt status: a new event beats a simultaneous clear
    logic [7:0] flags_d1_q;
    assign flags = {warn_o, alarm_o, open_flag_o};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_d1_q <= 8'h00;
            ist_q <= 8'h00;
        end else begin
            flags_d1_q <= flags;
            ist_q <= (ist_q & ~((wr_i && addr_i == pvs_pkg::A_ICLR) ?
                wdata_i[7:0] : 8'h00)) | (flags & ~flags_d1_q);
        end
    end
    assign irq_o = |(ist_q & ien_q);

    // read port, data one cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                pvs_pkg::A_CTRL: rdata_o <= {30'h0, ctrl_q[1:0]};
                pvs_pkg::A_AVGN: rdata_o <= {24'h0, avgn_q};
                pvs_pkg::A_RLO: rdata_o <= {16'h0, rlo_q};
                pvs_pkg::A_RHI: rdata_o <= {16'h0, rhi_q};
                pvs_pkg::A_HYPV: rdata_o <= {16'h0, hypv_q};
                pvs_pkg::A_HYRT: rdata_o <= {16'h0, hyrt_q};
                pvs_pkg::A_ONDLY: rdata_o <= {26'h0, ondly_q};
                pvs_pkg::A_RINT: rdata_o <= {27'h0, rint_q};
                pvs_pkg::A_CPER: rdata_o <= {16'h0, cper_q};
                pvs_pkg::A_NOTE: rdata_o <= {16'h0, note_q};
                pvs_pkg::A_PV: rdata_o <= {16'h0, pv_q};
                pvs_pkg::A_RATE: rdata_o <= {16'h0, rate_q};
                pvs_pkg::A_FLAGS: rdata_o <= {24'h0, flags};
                pvs_pkg::A_PEAK: rdata_o <= {16'h0, peak_q};
                pvs_pkg::A_BOT: rdata_o <= {16'h0, bot_q};
                pvs_pkg::A_TOP: rdata_o <= {16'h0, top_q};
                pvs_pkg::A_VAL: rdata_o <= {16'h0, val_q};
                pvs_pkg::A_DAY: rdata_o <= {16'h0, day_q};
                pvs_pkg::A_CDAY: rdata_o <= {16'h0, cday_q};
                pvs_pkg::A_IST: rdata_o <= {24'h0, ist_q};
                pvs_pkg::A_IEN: rdata_o <= {24'h0, ien_q};
                default: begin
                    rdata_o <= 32'h0;
                    for (int i = 0; i < pvs_pkg::NALM; i++) begin
                        if (addr_i == pvs_pkg::A_THR0 + 8'(4 * i))
                            rdata_o <= {16'h0, thr_q[i]};
                    end
                end
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // checks
    a_open_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        open_raw_i |=> open_flag_o) else $error("open flag late");
    a_open_force: assert property (@(posedge clk_i) disable iff (rst_i)
        open_flag_o |=> pv_q == $past(ovr[15:0]))
        else $error("pv not forced");
    a_fill_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        fill_q <= avgn_q || $changed(avgn_q) || avgn_d1_q != avgn_q)
        else $error("window overfilled");
    a_alarm_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(alarm_o[0]) |-> $past(raw_q[0]) && $past(dcnt_q[0] >= ondly_q))
        else $error("alarm before on-delay");
    a_alarm_hyst: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(raw_q[0]) |-> $past(ext(pv_q)) < $past(ext(thr_q[0]))
        - $past(ext(hypv_q))) else $error("alarm cleared in band");
    a_rate_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(rate_q) |-> $past(sec_tick))
        else $error("rate off interval");
    a_cal_store: assert property (@(posedge clk_i) disable iff (rst_i)
        cal_q |=> cday_q == $past(day_q)) else $error("date lost");
    a_peak_order: assert property (@(posedge clk_i) disable iff (rst_i)
        hold && hold_d1_q |-> $signed(peak_q) >= $signed(bot_q))
        else $error("peak below bottom");
    a_hold_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        !hold ##1 !hold |-> $stable(peak_q) && $stable(top_q))
        else $error("capture outside window");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(open_flag_o) ##1 ien_q[0] |-> irq_o)
        else $error("event not signalled");
    c_open: cover property (@(posedge clk_i) $rose(open_flag_o));
    c_alarm: cover property (@(posedge clk_i) $rose(alarm_o[1]));
    c_warn: cover property (@(posedge clk_i) $rose(warn_o));
    c_top: cover property (@(posedge clk_i) hold && $changed(top_q));
endmodule
`default_nettype wire

//--- sim/pvs_frontend.sv
// Purpose: converter front end model feeding the supervisor
// Assumes: bench requests at most one sample every few cycles
// Notes: sample bus shows inverted junk outside the valid pulse
`timescale 1ns/100ps
`default_nettype none
module pvs_frontend (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench side
    input wire logic req_i,
    input wire logic [15:0] val_i,
    input wire logic brk_i,
    // supervisor side
    output logic sample_vld_o,
    output logic [15:0] sample_o,
    output logic open_raw_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_vld_o <= 1'b0;
            sample_o <= 16'h0000;
            open_raw_o <= 1'b0;
        end else begin
            open_raw_o <= brk_i;
            // spacing of at least two cycles between pulses
            if (req_i && !sample_vld_o) begin
                sample_vld_o <= 1'b1;
                sample_o <= val_i;
            end else begin
                sample_vld_o <= 1'b0;
                sample_o <= ~sample_o;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/pvs_supervisor_tb.sv
// Purpose: self-checking bench of the process value supervisor
// Assumes: second shortened to 10 cycles and day to 4 seconds
// Notes: read data are checked against a queue of expected words
`timescale 1ns/100ps
`default_nettype none
module pvs_supervisor_tb;
    logic clk_i, rst_i, rd_i, wr_i, req, brk, vld, opn, pend;
    logic open_flag_o, warn_o, irq_o;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, seed, sum;
    logic [15:0] val, smp, v;
    logic [5:0] alarm_o;
    logic [31:0] expq[$];
    logic [15:0] thr[4] = '{16'h07d0, 16'h03e8, 16'hfc18, 16'hf830};
    logic [15:0] sv[6] = '{16'h09c4, 16'h079e, 16'h073a, 16'h0352,
                           16'hf63c, 16'hfcae};
    logic [3:0] ea[6] = '{4'h3, 4'h3, 4'h2, 4'h0, 4'hc, 4'h0};
    logic [15:0] pk[4] = '{16'h0032, 16'h0014, 16'hffe2, 16'h0005};
    int err_count, comparisons;
    wire [8:0] st = {irq_o, warn_o, open_flag_o, alarm_o};

    pvs_frontend fe (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .val_i(val), .brk_i(brk), .sample_vld_o(vld), .sample_o(smp),
        .open_raw_o(opn));
    pvs_supervisor #(.SEC_CYC(10), .DAY_S(4)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .sample_vld_i(vld), .sample_i(smp),
        .open_raw_i(opn), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .open_flag_o(open_flag_o),
        .alarm_o(alarm_o), .warn_o(warn_o), .irq_o(irq_o));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) pend <= rd_i;
    always @(negedge clk_i) begin
        if (pend === 1'b1) begin
            chk(rdata_o, expq.pop_front());
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        expq.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    task sm(input logic [15:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        val <= d;
        @(posedge clk_i);
        req <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // hold: masked status must stay at w; else it must reach w in time
    task wst(input logic [8:0] m, input logic [8:0] w, input int lim,
             input bit hold);
        logic ok;
        ok = hold;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_i);
            if (((st & m) === w) != hold) begin
                ok = !hold;
                break;
            end
        end
        chk({23'h0, ok ? w : (st & m)}, {23'h0, w});
        if (!ok && !hold) close_out;
    endtask

    task tdone(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        rst_i = 1'b1;
        rd_i = 1'b0;
        wr_i = 1'b0;
        req = 1'b0;
        brk = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        val = 16'h0000;
        seed = 32'h000054a2;
        err_count = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(pvs_pkg::A_AVGN, 32'h4);
        rd(pvs_pkg::A_RHI, 32'h2710);
        rd(pvs_pkg::A_RLO, 32'h0);
        rd(pvs_pkg::A_RINT, 32'h1);
        wr(8'h70, 32'hffff);
        rd(8'h70, 32'h0);
        rd(pvs_pkg::A_ICLR, 32'h0);
        // rate alarms kept quiet until their own test
        wr(pvs_pkg::A_THR0 + 8'h10, 32'h7fff);
        wr(pvs_pkg::A_THR0 + 8'h14, 32'h8000);
        tdone("reset");
        wr(pvs_pkg::A_AVGN, 32'hc8);
        rd(pvs_pkg::A_AVGN, 32'h80);
        wr(pvs_pkg::A_AVGN, 32'h0);
        rd(pvs_pkg::A_AVGN, 32'h1);
        wr(pvs_pkg::A_AVGN, 32'h4);
        sum = 32'h0;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = {4'h0, seed[9:0], 2'b00};
            sum = sum + {16'h0, v};
            sm(v);
        end
        rd(pvs_pkg::A_PV, sum >> 2);
        tdone("average");
        wr(pvs_pkg::A_AVGN, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(pvs_pkg::A_THR0 + 8'(i * 4), {16'h0, thr[i]});
        end
        wr(pvs_pkg::A_HYPV, 32'h64);
        for (int i = 0; i < 6; i++) begin
            sm(sv[i]);
            wst(9'h00f, {5'h00, ea[i]}, i == 1 ? 8 : 12, i == 1);
        end
        wr(pvs_pkg::A_ONDLY, 32'h2);
        sm(16'h05dc);
        wst(9'h002, 9'h000, 8, 1);
        wst(9'h002, 9'h002, 30, 0);
        wr(pvs_pkg::A_ONDLY, 32'h0);
        sm(16'h0352);
        wst(9'h00f, 9'h000, 12, 0);
        tdone("alarms");
        wr(pvs_pkg::A_IEN, 32'h1);
        wr(pvs_pkg::A_ICLR, 32'hff);
        wr(pvs_pkg::A_CTRL, 32'h2);
        @(posedge clk_i);
        brk <= 1'b1;
        wst(9'h040, 9'h040, 4, 0);
        wst(9'h100, 9'h100, 3, 0);
        repeat (10) @(posedge clk_i);
        rd(pvs_pkg::A_PV, 32'h2cec);
        rd(pvs_pkg::A_IST, 32'h7);
        wr(pvs_pkg::A_IEN, 32'h0);
        wst(9'h100, 9'h000, 3, 0);
        wr(pvs_pkg::A_IEN, 32'h1);
        wst(9'h100, 9'h100, 3, 0);
        wr(pvs_pkg::A_ICLR, 32'h1);
        wst(9'h100, 9'h000, 3, 0);
        rd(pvs_pkg::A_IST, 32'h6);
        wr(pvs_pkg::A_CTRL, 32'h0);
        repeat (6) @(posedge clk_i);
        rd(pvs_pkg::A_PV, 32'hfa24);
        brk <= 1'b0;
        wst(9'h040, 9'h000, 4, 0);
        tdone("open");
        sm(16'h000a);
        wr(pvs_pkg::A_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            sm(pk[i]);
        end
        wr(pvs_pkg::A_CTRL, 32'h0);
        rd(pvs_pkg::A_PEAK, 32'h32);
        rd(pvs_pkg::A_BOT, 32'hffe2);
        rd(pvs_pkg::A_TOP, 32'h32);
        rd(pvs_pkg::A_VAL, 32'hffe2);
        tdone("capture");
        wr(pvs_pkg::A_THR0 + 8'h10, 32'h96);
        repeat (25) @(posedge clk_i);
        rd(pvs_pkg::A_RATE, 32'h0);
        sm(16'h0131);
        wst(9'h010, 9'h010, 25, 0);
        rd(pvs_pkg::A_RATE, 32'h12c);
        wst(9'h010, 9'h000, 25, 0);
        wr(pvs_pkg::A_THR0 + 8'h14, 32'hff6a);
        sm(16'h0005);
        wst(9'h020, 9'h020, 25, 0);
        wst(9'h020, 9'h000, 25, 0);
        tdone("rate");
        wr(pvs_pkg::A_CPER, 32'h3);
        wr(pvs_pkg::A_NOTE, 32'h1);
        wr(pvs_pkg::A_CTRL, 32'h4);
        rd(pvs_pkg::A_CTRL, 32'h0);
        wst(9'h080, 9'h000, 35, 1);
        wst(9'h080, 9'h080, 130, 0);
        tdone("warning");
        repeat (3) @(posedge clk_i);
        close_out;
    end
endmodule
`default_nettype wire
